/* alert_source_merge.sv */
// masks status flags and live comparisons with the enable bits
`include "sac_regs.svh"

module alert_source_merge (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // configuration and sources, indexed by enable bit position
    input wire logic [15:0] cfg_i,
    input wire logic [15:0] flags_i,
    input wire logic [15:0] compare_i,
    // merged results
    output logic alert_any_o,
    output logic compare_any_o
);
    import sac_pkg::*;

    merge_state_t q;
    merge_state_t next_q;

    function automatic logic masked_any(input logic [15:0] en, input logic [15:0] src,
                                        input logic [15:0] sel);
        masked_any = |(en & src & sel);
    endfunction

    always_comb begin
        next_q = q;
        next_q.alert_any = masked_any(cfg_i, flags_i, `SAC_ALERT_MASK); // see R21
        // only warning positions pass, so fault enables cannot reach the pin
        next_q.compare_any = masked_any(cfg_i, compare_i, `SAC_WARN_MASK); // see R18 // see R19
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign alert_any_o = q.alert_any;
    assign compare_any_o = q.compare_any;

endmodule // alert_source_merge

/* output_pin_drive.sv */
// selects the pin source by mode and applies polarity
`include "sac_regs.svh"

module output_pin_drive (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // configuration
    input wire sac_pkg::out_mode_t mode_i,
    input wire logic polarity_i,
    // sources
    input wire logic alert_any_i,
    input wire logic compare_any_i,
    // pin
    output logic pin_o,
    output logic asserted_o
);
    import sac_pkg::*;

    drive_state_t q;
    drive_state_t next_q;
    logic active;

    always_comb begin
        next_q = q;
        active = 1'b0;
        case (mode_i)
            MODE_ALERT: active = alert_any_i; // see R15 // see R21
            MODE_COMPARE: active = compare_any_i; // see R17
            default: active = 1'b0; // reserved code holds the pin inactive
        endcase
        if (mode_i == MODE_GPIO) begin
            next_q.pin = polarity_i; // see R16
            next_q.asserted = polarity_i;
        end else begin
            next_q.pin = ~(active ^ polarity_i); // see R20
            next_q.asserted = active;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            q <= '{pin: 1'b1, asserted: 1'b0};
        end else begin
            q <= next_q;
        end
    end

    assign pin_o = q.pin;
    assign asserted_o = q.asserted;

endmodule // output_pin_drive

/* pmbus_host_model.sv */
// bus host model that issues word commands on the block's command port
module pmbus_host_model (
    input wire logic clk_i,
    // requests
    output logic cmd_valid_o,
    output logic [7:0] cmd_code_o,
    output logic wr_byte_valid_o,
    output logic [7:0] wr_byte_o,
    output logic rd_byte_req_o,
    output logic xfer_end_o,
    // answers
    input wire logic cmd_ack_i,
    input wire logic cmd_nack_i,
    input wire logic rd_byte_valid_i,
    input wire logic [7:0] rd_byte_i,
    input wire logic wr_error_i
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {cmd_valid_o, wr_byte_valid_o, rd_byte_req_o, xfer_end_o} = 4'h0;
        cmd_code_o = 8'h00;
        wr_byte_o = 8'h00;
    end
    // resp is {ack, nack, write error}; reads with no answer stay unknown
    task automatic xfer(input logic [7:0] code, input int nwr, input logic [23:0] wd,
        input int nrd, output logic [23:0] rd, output logic [2:0] resp);
        rd = 'x;
        @(negedge clk_i);
        cmd_valid_o = 1'b1;
        cmd_code_o = code;
        @(negedge clk_i);
        cmd_valid_o = 1'b0;
        cmd_code_o = ~code;
        resp[2:1] = {cmd_ack_i, cmd_nack_i};
        if (nwr > 0) begin
            wr_byte_valid_o = 1'b1;
            for (int i = 0; i < nwr; i++) begin
                wr_byte_o = wd[8*i+:8];
                @(negedge clk_i);
            end
            wr_byte_valid_o = 1'b0;
            // released data lines do not keep the last byte
            wr_byte_o = ~wr_byte_o;
        end
        if (nrd > 0) begin
            rd_byte_req_o = 1'b1;
            for (int i = 0; i < nrd; i++) begin
                @(negedge clk_i);
                if (rd_byte_valid_i === 1'b1) rd[8*i+:8] = rd_byte_i;
            end
            rd_byte_req_o = 1'b0;
        end
        xfer_end_o = 1'b1;
        @(negedge clk_i);
        xfer_end_o = 1'b0;
        resp[0] = wr_error_i;
    endtask
endmodule // pmbus_host_model

/* sac_checker_sva.sv */
// port assertions for the secondary alert output block
module sac_checker (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // command port
    input wire logic cmd_valid_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic cmd_ack_o,
    input wire logic cmd_nack_o,
    input wire logic wr_error_o,
    input wire logic [15:0] config_word_o,
    // sources and pin
    input wire logic switch_health_fault_flag_i,
    input wire logic overcurrent_warning_cmp_i,
    input wire logic secondary_output_pin_o,
    input wire logic alert_active_o
);
    wire [1:0] mode = config_word_o[2:1];
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    chk_cmd_ack: assert property (cmd_valid_i && cmd_code_i == 8'hd6 |=> cmd_ack_o)
        else $error("own command code not acknowledged");
    chk_cmd_nack: assert property (cmd_valid_i && cmd_code_i != 8'hd6 |=> cmd_nack_o && !cmd_ack_o)
        else $error("foreign command code not refused");
    chk_reset_word: assert property (disable iff (1'b0) !rst_n_i |=> config_word_o == 16'h8000)
        else $error("configuration word wrong after reset");
    chk_error_keeps: assert property (wr_error_o |-> config_word_o == $past(config_word_o))
        else $error("bad write changed the configuration");
    // the pin takes the polarity bit one edge late, so it is held against last cycle's bit
    chk_pin_polarity: assert property ((mode != 2'b01)[*3] |->
        secondary_output_pin_o == (alert_active_o ~^ $past(config_word_o[0])))
        else $error("pin level disagrees with polarity");
    chk_gpio_level: assert property ((mode == 2'b01 && $stable(config_word_o[0]))[*3] |->
        secondary_output_pin_o == config_word_o[0] && alert_active_o == config_word_o[0])
        else $error("plain output does not follow polarity bit");
    chk_health_alert: assert property ((mode == 2'b00 && config_word_o[15] &&
        switch_health_fault_flag_i && $stable(config_word_o))[*3] |-> alert_active_o)
        else $error("enabled health fault not alerted");
    chk_masked_quiet: assert property ((mode == 2'b00 && config_word_o[15:3] == 13'h0)[*3] |->
        !alert_active_o)
        else $error("alert raised with every source masked");
    chk_compare_or: assert property ((mode == 2'b11 && config_word_o[10] &&
        overcurrent_warning_cmp_i)[*3] |-> alert_active_o)
        else $error("selected comparison not shown on pin");
    chk_compare_faults: assert property ((mode == 2'b11 &&
        (config_word_o & 16'h07e8) == 16'h0)[*3] |-> !alert_active_o)
        else $error("fault enable acted in comparator mode");

    cover property (cmd_ack_o);
    cover property (wr_error_o);
    cover property (mode == 2'b11 && alert_active_o);
    cover property (mode == 2'b01 && secondary_output_pin_o);
endmodule // sac_checker

bind secondary_alert_output_config sac_checker u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i), .cmd_ack_o(cmd_ack_o),
    .cmd_nack_o(cmd_nack_o), .wr_error_o(wr_error_o), .config_word_o(config_word_o),
    .switch_health_fault_flag_i(switch_health_fault_flag_i),
    .overcurrent_warning_cmp_i(overcurrent_warning_cmp_i),
    .secondary_output_pin_o(secondary_output_pin_o), .alert_active_o(alert_active_o));

/* sac_pkg.sv */
// types shared by the secondary alert output block
package sac_pkg;

    typedef enum logic [1:0] {
        MODE_ALERT = 2'b00,
        MODE_GPIO = 2'b01,
        MODE_RSVD = 2'b10,
        MODE_COMPARE = 2'b11
    } out_mode_t;

    typedef enum logic [1:0] {
        XFER_IDLE = 2'b00,
        XFER_SELECTED = 2'b01,
        XFER_LOW_HELD = 2'b10,
        XFER_HIGH_HELD = 2'b11
    } xfer_state_t;

    typedef struct packed {
        xfer_state_t st;
        logic [15:0] cfg;
        logic [7:0] low_byte;
        logic [7:0] high_byte;
        logic [1:0] rd_count;
        logic overflow;
        logic ack;
        logic nack;
        logic rd_valid;
        logic [7:0] rd_byte;
        logic wr_error;
    } cfg_state_t;

    typedef struct packed {
        logic alert_any;
        logic compare_any;
    } merge_state_t;

    typedef struct packed {
        logic pin;
        logic asserted;
    } drive_state_t;

endpackage

/* sac_regs.svh */
// register offsets, field positions and reset values of the secondary alert output block
// Functional notes
// R1: 16-bit read/write word config register at command 0xd6, reset value 0x8000.
// R2: bit 15 lets the switch health fault alert; set from reset.
// R3: bit 14 lets the output overcurrent fault flag raise the alert.
// R4: bit 13 lets the input overvoltage fault flag raise the alert.
// R5: bit 12 lets the input undervoltage fault flag raise the alert.
// R6: bit 11 lets the communication, memory or logic error flag raise the alert.
// R7: bit 10 lets the output overcurrent warning flag raise the alert.
// R8: bit 9 lets the second current warning flag raise the alert.
// R9: bit 8 lets the input overvoltage warning flag raise the alert.
// R10: bit 7 lets the input undervoltage warning flag raise the alert.
// R11: bit 6 lets the output overvoltage warning flag raise the alert.
// R12: bit 5 lets the output undervoltage warning flag raise the alert.
// R13: bit 4 lets the current limit active flag raise the alert.
// R14: bit 3 lets the input overpower warning flag raise the alert.
// R15: mode 00 makes the pin an alert source; software never writes code 10.
// R16: mode 01 makes the pin a plain output driven by the polarity bit.
// R17: mode 11 shows live, unlatched warning comparisons on the pin.
// R18: in mode 11 the selected warning comparisons are ORed together.
// R19: in mode 11 fault and error enable bits are ignored.
// R20: polarity bit 0 clear gives an active low pin, set gives active high.
// R21: alert mode holds the pin asserted while any enabled flag stays set.
`ifndef SAC_REGS_SVH
`define SAC_REGS_SVH

`define SAC_CMD_CODE 8'hd6
`define SAC_CFG_RESET 16'h8000
`define SAC_BIT_SWITCH_HEALTH 15
`define SAC_BIT_OC_FAULT 14
`define SAC_BIT_INPUT_OVERVOLTAGE_FAULT_FLAG 13
`define SAC_BIT_INPUT_UNDERVOLTAGE_FAULT_FLAG 12
`define SAC_BIT_COMM_ERROR 11
`define SAC_BIT_OC_WARN 10
`define SAC_BIT_CUR2_WARN 9
`define SAC_BIT_INPUT_OVERVOLTAGE_WARNING_FLAG 8
`define SAC_BIT_INPUT_UNDERVOLTAGE_WARNING_FLAG 7
`define SAC_BIT_OUTPUT_OVERVOLTAGE_WARNING_FLAG 6
`define SAC_BIT_OUTPUT_UNDERVOLTAGE_WARNING_FLAG 5
`define SAC_BIT_CUR_LIMIT 4
`define SAC_BIT_INPUT_OVERPOWER_WARNING_FLAG 3
`define SAC_MODE_HI 2
`define SAC_MODE_LO 1
`define SAC_BIT_POLARITY 0
// enable bits that may raise the alert (15..3) and those that are threshold warnings
`define SAC_ALERT_MASK 16'hfff8
`define SAC_WARN_MASK 16'h07e8
// answer to a read beyond the two bytes of the word
`define SAC_READ_FILL 8'hff

`endif

/* secondary_alert_output_config.sv */
// configuration word and command access for the secondary alert output pin
`include "sac_regs.svh"

module secondary_alert_output_config (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // command port from the bus engine
    input wire logic cmd_valid_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic wr_byte_valid_i,
    input wire logic [7:0] wr_byte_i,
    input wire logic rd_byte_req_i,
    input wire logic xfer_end_i,
    // command port answers
    output logic cmd_ack_o,
    output logic cmd_nack_o,
    output logic rd_byte_valid_o,
    output logic [7:0] rd_byte_o,
    output logic wr_error_o,
    output logic [15:0] config_word_o,
    // latched status flags
    input wire logic switch_health_fault_flag_i,
    input wire logic overcurrent_fault_flag_i,
    input wire logic input_overvoltage_fault_flag_i,
    input wire logic input_undervoltage_fault_flag_i,
    input wire logic comm_logic_error_flag_i,
    input wire logic overcurrent_warning_flag_i,
    input wire logic second_current_warning_flag_i,
    input wire logic input_overvoltage_warning_flag_i,
    input wire logic input_undervoltage_warning_flag_i,
    input wire logic output_overvoltage_warning_flag_i,
    input wire logic output_undervoltage_warning_flag_i,
    input wire logic current_limit_active_flag_i,
    input wire logic input_overpower_warning_flag_i,
    // live threshold comparisons, not latched
    input wire logic overcurrent_warning_cmp_i,
    input wire logic second_current_warning_cmp_i,
    input wire logic input_overvoltage_warning_cmp_i,
    input wire logic input_undervoltage_warning_cmp_i,
    input wire logic output_overvoltage_warning_cmp_i,
    input wire logic output_undervoltage_warning_cmp_i,
    input wire logic input_overpower_warning_cmp_i,
    // pin
    output logic secondary_output_pin_o,
    output logic alert_active_o
);
    import sac_pkg::*;

    cfg_state_t q;
    cfg_state_t next_q;
    logic [15:0] flags;
    logic [15:0] compare;
    logic alert_any;
    logic compare_any;

    // word order on the bus is low byte first
    function automatic logic [7:0] word_byte(input logic [15:0] word,
                                             input logic [1:0] index);
        case (index)
            2'd0: word_byte = word[7:0];
            2'd1: word_byte = word[15:8];
            default: word_byte = `SAC_READ_FILL;
        endcase
    endfunction

    // flags sit at the position of their enable bit
    always_comb begin
        flags = '0;
        flags[`SAC_BIT_SWITCH_HEALTH] = switch_health_fault_flag_i; // see R2
        flags[`SAC_BIT_OC_FAULT] = overcurrent_fault_flag_i; // see R3
        flags[`SAC_BIT_INPUT_OVERVOLTAGE_FAULT_FLAG] = input_overvoltage_fault_flag_i; // see R4
        flags[`SAC_BIT_INPUT_UNDERVOLTAGE_FAULT_FLAG] = input_undervoltage_fault_flag_i; // see R5
        flags[`SAC_BIT_COMM_ERROR] = comm_logic_error_flag_i; // see R6
        flags[`SAC_BIT_OC_WARN] = overcurrent_warning_flag_i; // see R7
        flags[`SAC_BIT_CUR2_WARN] = second_current_warning_flag_i; // see R8
        flags[`SAC_BIT_INPUT_OVERVOLTAGE_WARNING_FLAG] = input_overvoltage_warning_flag_i; // see R9
        flags[`SAC_BIT_INPUT_UNDERVOLTAGE_WARNING_FLAG] = input_undervoltage_warning_flag_i; // see R10
        flags[`SAC_BIT_OUTPUT_OVERVOLTAGE_WARNING_FLAG] = output_overvoltage_warning_flag_i; // see R11
        flags[`SAC_BIT_OUTPUT_UNDERVOLTAGE_WARNING_FLAG] = output_undervoltage_warning_flag_i; // see R12
        flags[`SAC_BIT_CUR_LIMIT] = current_limit_active_flag_i; // see R13
        flags[`SAC_BIT_INPUT_OVERPOWER_WARNING_FLAG] = input_overpower_warning_flag_i; // see R14
    end

    // comparator mode sees only the threshold warnings
    always_comb begin
        compare = '0;
        compare[`SAC_BIT_OC_WARN] = overcurrent_warning_cmp_i; // see R17
        compare[`SAC_BIT_CUR2_WARN] = second_current_warning_cmp_i;
        compare[`SAC_BIT_INPUT_OVERVOLTAGE_WARNING_FLAG] = input_overvoltage_warning_cmp_i;
        compare[`SAC_BIT_INPUT_UNDERVOLTAGE_WARNING_FLAG] = input_undervoltage_warning_cmp_i;
        compare[`SAC_BIT_OUTPUT_OVERVOLTAGE_WARNING_FLAG] = output_overvoltage_warning_cmp_i;
        compare[`SAC_BIT_OUTPUT_UNDERVOLTAGE_WARNING_FLAG] = output_undervoltage_warning_cmp_i;
        compare[`SAC_BIT_INPUT_OVERPOWER_WARNING_FLAG] = input_overpower_warning_cmp_i;
    end

    // state after reset: stored word at its default, no transfer open
    function automatic cfg_state_t reset_state();
        cfg_state_t n;
        n.st = XFER_IDLE;
        n.cfg = `SAC_CFG_RESET; // see R1 // see R2
        n.low_byte = 8'h00;
        n.high_byte = 8'h00;
        n.rd_count = 2'd0;
        n.overflow = 1'b0;
        n.ack = 1'b0;
        n.nack = 1'b0;
        n.rd_valid = 1'b0;
        n.rd_byte = 8'h00;
        n.wr_error = 1'b0;
        return n;
    endfunction

    // a command opens a transfer only for our own code
    function automatic cfg_state_t take_command(input cfg_state_t s,
                                                input logic [7:0] code);
        cfg_state_t n;
        n = s;
        n.rd_count = 2'd0;
        n.overflow = 1'b0;
        if (code == `SAC_CMD_CODE) begin
            n.st = XFER_SELECTED; // see R1
            n.ack = 1'b1;
        end else begin
            n.st = XFER_IDLE;
            n.nack = 1'b1;
        end
        return n;
    endfunction

    // the end of a transfer commits a whole word or reports a bad write
    function automatic cfg_state_t take_end(input cfg_state_t s);
        cfg_state_t n;
        n = s;
        n.st = XFER_IDLE;
        case (s.st)
            XFER_HIGH_HELD: begin
                if (s.overflow) begin
                    n.wr_error = 1'b1;
                end else begin
                    // only a whole word is taken, so a byte write cannot
                    // leave half a configuration in force
                    n.cfg = {s.high_byte, s.low_byte}; // see R1
                end
            end
            XFER_LOW_HELD: begin
                n.wr_error = 1'b1;
            end
            default: begin
                n.wr_error = 1'b0;
            end
        endcase
        return n;
    endfunction

    // write bytes fill low then high; a third byte only marks the overflow
    function automatic cfg_state_t take_write(input cfg_state_t s,
                                              input logic [7:0] data);
        cfg_state_t n;
        n = s;
        case (s.st)
            XFER_SELECTED: begin
                if (s.rd_count == 2'd0) begin
                    n.low_byte = data;
                    n.st = XFER_LOW_HELD;
                end
            end
            XFER_LOW_HELD: begin
                n.high_byte = data;
                n.st = XFER_HIGH_HELD;
            end
            XFER_HIGH_HELD: begin
                n.overflow = 1'b1;
            end
            default: begin
                n.overflow = s.overflow;
            end
        endcase
        return n;
    endfunction

    // reads step through the word and stop counting at the fill position
    function automatic cfg_state_t take_read(input cfg_state_t s);
        cfg_state_t n;
        n = s;
        if (s.st == XFER_SELECTED) begin
            n.rd_valid = 1'b1;
            n.rd_byte = word_byte(s.cfg, s.rd_count);
            if (s.rd_count != 2'd2) begin
                n.rd_count = s.rd_count + 2'd1;
            end
        end
        return n;
    endfunction

    // command port, one pulse per event, every answer one cycle after its edge:
    //   write: command, low byte, high byte, end of transfer
    //   read: command, one request per byte, end of transfer
    // a foreign command code gets a nack and leaves the block idle, so the
    // bytes, reads and end that follow it are dropped without any answer
    // the stored word changes only at the end of a two-byte write; one byte
    // or a third byte gives a write error pulse and keeps the old word, so a
    // host that lost a byte on the wire cannot leave a half-written mask
    // a transfer keeps one direction: a write byte after a read, or a read
    // after a write byte, is ignored
    // reads past the high byte answer with the fill byte for as long as asked
    // the pin path adds two register stages after a flag or comparison moves
    // limitation: software must keep off the reserved mode; if it writes it,
    // the word is stored as written and the pin is parked inactive
    // command sequencing: a new command outranks the end of a transfer,
    // which outranks data bytes, which outrank read requests
    always_comb begin
        next_q = q;
        next_q.ack = 1'b0;
        next_q.nack = 1'b0;
        next_q.rd_valid = 1'b0;
        next_q.wr_error = 1'b0;
        if (cmd_valid_i) begin
            next_q = take_command(next_q, cmd_code_i);
        end else if (xfer_end_i) begin
            next_q = take_end(next_q);
        end else if (wr_byte_valid_i) begin
            next_q = take_write(next_q, wr_byte_i);
        end else if (rd_byte_req_i) begin
            next_q = take_read(next_q);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            q <= reset_state();
        end else begin
            q <= next_q;
        end
    end

    // one register stage here keeps the flag fan-in away from the mode mux
    alert_source_merge u_merge (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .cfg_i(q.cfg),
        .flags_i(flags),
        .compare_i(compare),
        .alert_any_o(alert_any),
        .compare_any_o(compare_any)
    );

    // a reserved mode code written anyway parks the pin at its inactive level
    output_pin_drive u_drive (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .mode_i(out_mode_t'(q.cfg[`SAC_MODE_HI:`SAC_MODE_LO])), // see R15
        .polarity_i(q.cfg[`SAC_BIT_POLARITY]), // see R20
        .alert_any_i(alert_any),
        .compare_any_i(compare_any),
        .pin_o(secondary_output_pin_o),
        .asserted_o(alert_active_o)
    );

    assign cmd_ack_o = q.ack;
    assign cmd_nack_o = q.nack;
    assign rd_byte_valid_o = q.rd_valid;
    assign rd_byte_o = q.rd_byte;
    assign wr_error_o = q.wr_error;
    assign config_word_o = q.cfg;

endmodule // secondary_alert_output_config

/* secondary_alert_output_config_tb.sv */
// self-checking bench for the secondary alert output block
module secondary_alert_output_config_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [15:0] flg = 16'h0;
    logic [15:0] cmp = 16'h0;
    logic [15:0] cur = 16'h8000;
    logic [31:0] rnd = 32'hd005;
    logic cv, wv, rq, xe, ack, nack, rv, we, pin, act;
    logic [7:0] cc, wb, rb;
    logic [15:0] cfg, c;
    logic [23:0] rd;
    logic [2:0] rsp;
    int errors = 0;
    int n_checks = 0;

    always #2 clk_i = ~clk_i;

    pmbus_host_model u_host (.clk_i(clk_i), .cmd_valid_o(cv), .cmd_code_o(cc),
        .wr_byte_valid_o(wv), .wr_byte_o(wb), .rd_byte_req_o(rq), .xfer_end_o(xe),
        .cmd_ack_i(ack), .cmd_nack_i(nack), .rd_byte_valid_i(rv), .rd_byte_i(rb),
        .wr_error_i(we));

    secondary_alert_output_config u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .cmd_valid_i(cv), .cmd_code_i(cc), .wr_byte_valid_i(wv), .wr_byte_i(wb),
        .rd_byte_req_i(rq), .xfer_end_i(xe), .cmd_ack_o(ack), .cmd_nack_o(nack),
        .rd_byte_valid_o(rv), .rd_byte_o(rb), .wr_error_o(we), .config_word_o(cfg),
        .switch_health_fault_flag_i(flg[15]), .overcurrent_fault_flag_i(flg[14]),
        .input_overvoltage_fault_flag_i(flg[13]), .input_undervoltage_fault_flag_i(flg[12]),
        .comm_logic_error_flag_i(flg[11]), .overcurrent_warning_flag_i(flg[10]),
        .second_current_warning_flag_i(flg[9]), .input_overvoltage_warning_flag_i(flg[8]),
        .input_undervoltage_warning_flag_i(flg[7]), .output_overvoltage_warning_flag_i(flg[6]),
        .output_undervoltage_warning_flag_i(flg[5]), .current_limit_active_flag_i(flg[4]),
        .input_overpower_warning_flag_i(flg[3]), .overcurrent_warning_cmp_i(cmp[10]),
        .second_current_warning_cmp_i(cmp[9]), .input_overvoltage_warning_cmp_i(cmp[8]),
        .input_undervoltage_warning_cmp_i(cmp[7]), .output_overvoltage_warning_cmp_i(cmp[6]),
        .output_undervoltage_warning_cmp_i(cmp[5]), .input_overpower_warning_cmp_i(cmp[3]),
        .secondary_output_pin_o(pin), .alert_active_o(act));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // expected {pin, asserted} for a config word, latched flags and live comparisons
    function automatic logic [1:0] exp_pin(input logic [15:0] k, f, m);
        logic a;
        a = (k[2:1] == 2'b00) ? |(k[15:3] & f[15:3]) : |(k & m & 16'h07e8);
        if (k[2:1] == 2'b01) return {k[0], k[0]};
        return {a ~^ k[0], a};
    endfunction

    task check(input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task print_verdict;
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task wr(input logic [15:0] v);
        u_host.xfer(8'hd6, 2, {8'h00, v}, 0, rd, rsp);
        cur = v;
        check({rsp, cfg}, {3'b100, v});
    endtask

    // the pin lags its sources by two edges, so three are allowed
    task settle(input logic [15:0] f, input logic [15:0] m);
        @(negedge clk_i);
        flg = f;
        cmp = m;
        repeat (3) @(negedge clk_i);
        check({pin, act}, exp_pin(cur, f, m));
    endtask

    initial begin
        repeat (12) @(negedge clk_i);
        rst_n_i = 1'b1;
        check({pin, act, cfg}, {2'b10, 16'h8000});
        u_host.xfer(8'hd6, 0, 24'h0, 2, rd, rsp);
        check({rsp, rd[15:0]}, {3'b100, 16'h8000});
        settle(16'h8000, 16'h0);
        settle(16'h7ff8, 16'hffff);
        repeat (4) begin
            rnd = lfsr(rnd);
            c[7:0] = (rnd[7:0] == 8'hd6) ? 8'hd5 : rnd[7:0];
            u_host.xfer(c[7:0], 2, 24'h1234, 1, rd, rsp);
            check({rsp, cfg}, {3'b010, cur});
        end
        for (int b = 3; b < 16; b++) begin
            wr(16'h1 << b);
            settle(~(16'h1 << b), 16'hffff);
            settle(16'h1 << b, 16'h0);
        end
        wr(16'hf816);
        settle(16'hffff, 16'hffff);
        wr(16'hfff6);
        for (int b = 3; b < 11; b++) settle(16'hffff, 16'h1 << b);
        wr(16'h0003);
        settle(16'h0, 16'h0);
        wr(16'h0002);
        settle(16'hffff, 16'hffff);
        u_host.xfer(8'hd6, 1, 24'h55, 0, rd, rsp);
        check({rsp, cfg}, {3'b101, cur});
        u_host.xfer(8'hd6, 3, 24'h123456, 0, rd, rsp);
        check({rsp, cfg}, {3'b101, cur});
        u_host.xfer(8'hd6, 0, 24'h0, 3, rd, rsp);
        check(rd, {8'hff, cur});
        repeat (100) begin
            rnd = lfsr(rnd);
            c = rnd[15:0] ^ rnd[31:16];
            if (c[2:1] == 2'b10) c[2:1] = 2'b11;
            wr(c);
            rnd = lfsr(rnd);
            settle(rnd[15:0] & rnd[31:16], rnd[15:0] & ~rnd[31:16]);
        end
        rst_n_i = 1'b0;
        @(negedge clk_i);
        rst_n_i = 1'b1;
        check({pin, act, cfg}, {2'b10, 16'h8000});
        print_verdict;
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        errors++;
        print_verdict;
    end
endmodule // secondary_alert_output_config_tb
